// ### rtl/dw_droop_wake.sv
// Purpose: Droop monitor control: reference hold, wake signalling, enable switch
// Assumes: uvlo_ok comes from a hysteretic supply comparator; vdd_level is a code
// Notes:   Open-drain pins: out is always low, oe high while pulling down
`timescale 1ns/10ps

module dw_droop_wake #(
  parameter int PCD_MIN_CYC  = dw_pkg::PCD_MIN_CYC,
  parameter int WAKE_PLS_CYC = dw_pkg::WAKE_PULSE_CYC,
  parameter int WAKE_REP_CYC = dw_pkg::WAKE_REP_CYC,
  parameter int ENS_CYC      = dw_pkg::ENS_QUAL_CYC,
  parameter int DISS_CYC     = dw_pkg::DISS_QUAL_CYC,
  parameter int DISS_COUNT   = dw_pkg::DISS_COUNT,
  parameter int ENS_COUNT    = dw_pkg::ENS_COUNT
) (
  input  wire logic                     clk_sys,
  input  wire logic                     nrst,
  input  wire logic                     uvlo_ok,
  input  wire logic [dw_pkg::VDD_W-1:0] vdd_level,
  input  wire logic                     alert_in,
  output logic                          alert_out,
  output logic                          alert_oe,
  output logic                          ens_out,
  output logic                          ens_oe,
  output logic                          wake_active,
  output logic                          ref_valid,
  output logic [dw_pkg::VDD_W-1:0]      droop_ref
);

  localparam int VW = dw_pkg::VDD_W;
  localparam int PW = dw_pkg::PERIOD_W;
  localparam int CW = dw_pkg::COUNT_W;

  localparam logic [PW-1:0] ENS_LIM  = PW'(ENS_CYC);
  localparam logic [PW-1:0] DISS_LIM = PW'(DISS_CYC);
  localparam logic [PW-1:0] PER_SAT  = PW'(DISS_CYC + 1);
  localparam logic [CW-1:0] DIS_LAST = CW'(DISS_COUNT - 1);
  localparam logic [CW-1:0] EN_FULL  = CW'(ENS_COUNT);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (ENS_CYC < 1 || ENS_CYC >= DISS_CYC || DISS_CYC + 1 >= (1 << PW)) begin : g_chk_per
    $error("dw_droop_wake: need 1 <= ENS_CYC < DISS_CYC < 2**PERIOD_W - 1");
  end
  if (DISS_COUNT < 1 || DISS_COUNT >= (1 << CW) || ENS_COUNT < 1 || ENS_COUNT >= (1 << CW)) begin : g_chk_cnt
    $error("dw_droop_wake: counts must fit COUNT_W bits");
  end
  if (PCD_MIN_CYC < 1 || WAKE_PLS_CYC < 1 || WAKE_REP_CYC <= WAKE_PLS_CYC) begin : g_chk_tim
    $error("dw_droop_wake: need detect and wake timing of at least one cycle");
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [VW-1:0] scale_ref(input logic [VW-1:0] v);
    logic [VW+6:0] prod;
    prod      = (VW + 7)'(v) * (VW + 7)'(dw_pkg::REF_NUM);
    scale_ref = VW'(prod / (VW + 7)'(dw_pkg::REF_DEN));
  endfunction

  dw_link_if link ();

  dw_pcd_filter #(
    .MIN_CYC (PCD_MIN_CYC)
  ) u_filt (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .link    (link)
  );

  dw_wake_gen #(
    .PULSE_CYC (WAKE_PLS_CYC),
    .REP_CYC   (WAKE_REP_CYC)
  ) u_gen (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .link    (link)
  );

  // Wake pulses are masked from detection while driving and the cycle before
  assign link.run       = uvlo_ok;
  assign link.alert_low = alert_in;
  assign link.mask      = link.pulse || alert_oe;
  assign link.wake_req  = wake_active;

  // ----------------------------------------
  // Reference hold and droop compare
  // ----------------------------------------
  logic [VW-1:0] next_droop_ref;
  logic          next_ref_valid;
  logic          next_wake_active;
  logic          below;

  assign below = ref_valid && (vdd_level < droop_ref);

  always_comb begin
    next_droop_ref   = droop_ref;
    next_ref_valid   = ref_valid;
    next_wake_active = wake_active;
    if (!uvlo_ok) begin
      next_droop_ref   = '0;
      next_ref_valid   = 1'b0;
      next_wake_active = 1'b0;
    end else if (link.pcd) begin
      // Detection both refreshes the threshold and ends any wake burst
      next_droop_ref   = scale_ref(vdd_level);
      next_ref_valid   = 1'b1;
      next_wake_active = 1'b0;
    end else if (below) begin
      next_wake_active = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      droop_ref   <= '0;
      ref_valid   <= 1'b0;
      wake_active <= 1'b0;
    end else begin
      droop_ref   <= next_droop_ref;
      ref_valid   <= next_ref_valid;
      wake_active <= next_wake_active;
    end
  end

  // ----------------------------------------
  // Alert pin driver
  // ----------------------------------------
  logic next_alert_oe;
  logic next_alert_out;

  always_comb begin
    next_alert_oe  = uvlo_ok && wake_active && link.pulse;
    // Open-drain: the data bit never leaves low
    next_alert_out = 1'b0;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      alert_oe  <= 1'b0;
      alert_out <= 1'b0;
    end else begin
      alert_oe  <= next_alert_oe;
      alert_out <= next_alert_out;
    end
  end

  // ----------------------------------------
  // Switching period measurement
  // ----------------------------------------
  logic [PW-1:0] period;
  logic [PW-1:0] next_period;
  logic          have_prev;
  logic          next_have_prev;
  logic          is_short;
  logic          is_long;

  assign is_short = period < ENS_LIM;
  assign is_long  = period > DISS_LIM;

  // Gaps past the maximum switching period are only ever seen as long
  always_comb begin
    next_period = period;
    if (!uvlo_ok) begin
      next_period = '0;
    end else if (link.pcd) begin
      // Restart timing from this detection
      next_period = PW'(1);
    end else if (period != PER_SAT) begin
      // Saturates: anything past the disable interval is simply long
      next_period = period + PW'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      period <= '0;
    end else begin
      period <= next_period;
    end
  end

  // ----------------------------------------
  // First detection after lockout
  // ----------------------------------------
  // The first detection has no earlier one to time against
  always_comb begin
    next_have_prev = have_prev;
    if (!uvlo_ok) begin
      next_have_prev = 1'b0;
    end else if (link.pcd) begin
      next_have_prev = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      have_prev <= 1'b0;
    end else begin
      have_prev <= next_have_prev;
    end
  end

  // ----------------------------------------
  // Enable switch events
  // ----------------------------------------
  logic          count_evt;
  logic          en_done;
  logic          sw_on;
  logic          next_sw_on;
  logic [CW-1:0] dis_cnt;
  logic [CW-1:0] next_dis_cnt;
  logic [CW-1:0] en_cnt;
  logic [CW-1:0] next_en_cnt;
  logic          next_ens_oe;
  logic          next_ens_out;

  // Only detections move the counts; wake bursts alone never do
  assign count_evt = uvlo_ok && link.pcd && have_prev;
  assign en_done   = is_short && (en_cnt >= EN_FULL - CW'(1));

  // ----------------------------------------
  // Consecutive long-period count
  // ----------------------------------------
  always_comb begin
    next_dis_cnt = dis_cnt;
    if (!uvlo_ok) begin
      next_dis_cnt = '0;
    end else if (count_evt && !sw_on) begin
      if (!is_long) begin
        next_dis_cnt = '0;
      end else if (dis_cnt == DIS_LAST) begin
        next_dis_cnt = '0;
      end else begin
        next_dis_cnt = dis_cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dis_cnt <= '0;
    end else begin
      dis_cnt <= next_dis_cnt;
    end
  end

  // ----------------------------------------
  // Cumulative short-period count
  // ----------------------------------------
  // Counted in both switch states, so a full count re-enables at once
  always_comb begin
    next_en_cnt = en_cnt;
    if (!uvlo_ok) begin
      next_en_cnt = '0;
    end else if (count_evt) begin
      if (sw_on && en_done) begin
        next_en_cnt = '0;
      end else if (is_short && en_cnt != EN_FULL) begin
        next_en_cnt = en_cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      en_cnt <= '0;
    end else begin
      en_cnt <= next_en_cnt;
    end
  end

  // ----------------------------------------
  // Switch state and pin
  // ----------------------------------------
  // The wide gap between the two intervals keeps the switch from chattering
  always_comb begin
    next_sw_on = sw_on;
    if (!uvlo_ok) begin
      next_sw_on = 1'b0;
    end else if (count_evt) begin
      if (!sw_on) begin
        next_sw_on = is_long && (dis_cnt == DIS_LAST);
      end else if (en_done) begin
        next_sw_on = 1'b0;
      end
    end
  end

  always_comb begin
    next_ens_oe  = next_sw_on;
    next_ens_out = 1'b0;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sw_on   <= 1'b0;
      ens_oe  <= 1'b0;
      ens_out <= 1'b0;
    end else begin
      sw_on   <= next_sw_on;
      ens_oe  <= next_ens_oe;
      ens_out <= next_ens_out;
    end
  end

endmodule

// ### rtl/dw_pkg.sv
// Purpose: Shared constants and types for the droop wake and enable-switch block
// Assumes: 200 MHz system clock; supply level arrives as an unsigned digital code
// Notes:   Times are kept in ns as printed, the maximum switching period in ms; cycle counts are derived from the ns ones

package dw_pkg;

  // ----------------------------------------
  // Clock and data widths
  // ----------------------------------------
  localparam int CLK_MHZ   = 200;
  localparam int VDD_W     = 10;
  localparam int PERIOD_W  = 16;
  localparam int COUNT_W   = 6;

  // ----------------------------------------
  // Reference scaling
  // ----------------------------------------
  localparam int REF_NUM   = 97;
  localparam int REF_DEN   = 100;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int PCD_MIN_NS     = 500;
  localparam int PCD_MIN_CYC    = (PCD_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_PULSE_NS  = 1000;
  localparam int WAKE_PULSE_CYC = (WAKE_PULSE_NS * CLK_MHZ) / 1000;
  localparam int WAKE_REP_NS    = 30000;
  localparam int WAKE_REP_CYC   = (WAKE_REP_NS * CLK_MHZ) / 1000;
  localparam int ENS_QUAL_NS    = 57000;
  localparam int ENS_QUAL_CYC   = (ENS_QUAL_NS * CLK_MHZ) / 1000;
  localparam int DISS_QUAL_NS   = 177000;
  localparam int DISS_QUAL_CYC  = (DISS_QUAL_NS * CLK_MHZ + 999) / 1000;
  localparam int MAX_SWITCHING_PERIOD_MS     = 40;

  // ----------------------------------------
  // Cycle counts for the enable switch
  // ----------------------------------------
  localparam int DISS_COUNT = 63;
  localparam int ENS_COUNT  = 32;

  // ----------------------------------------
  // Wake sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ws_idle,
    ws_pulse,
    ws_gap
  } dw_wake_state_type;

endpackage

// ### rtl/dw_link_if.sv
// Purpose: Carries detection and wake signals between the top and its helpers
// Assumes: All members on clk_sys
// Notes:   run doubles as the lockout gate for the helpers
`timescale 1ns/10ps

interface dw_link_if;
  logic run;
  logic alert_low;
  logic mask;
  logic pcd;
  logic wake_req;
  logic pulse;

  modport top  (output run, output alert_low, output mask, input pcd, output wake_req, input pulse);
  modport filt (input run, input alert_low, input mask, output pcd);
  modport gen  (input run, input wake_req, output pulse);
endinterface

// ### rtl/dw_pcd_filter.sv
// Purpose: Qualifies power cycles seen on the alert pin
// Assumes: alert_low is synchronous, high while the pin is below detect level
// Notes:   Pulse comes at the release of a long enough low phase
`timescale 1ns/10ps

module dw_pcd_filter #(
  parameter int MIN_CYC = dw_pkg::PCD_MIN_CYC
) (
  input  wire logic clk_sys,
  input  wire logic nrst,
  dw_link_if.filt   link
);

  localparam int CW = $clog2(MIN_CYC + 1);

  logic [CW-1:0] low_cnt;
  logic [CW-1:0] next_low_cnt;
  logic          pcd;
  logic          next_pcd;

  if (MIN_CYC < 1) begin : g_chk
    $error("dw_pcd_filter: MIN_CYC must be at least 1");
  end

  // ----------------------------------------
  // Low-phase timer
  // ----------------------------------------
  always_comb begin
    next_low_cnt = low_cnt;
    next_pcd     = 1'b0;
    if (!link.run || link.mask) begin
      // Own wake pulses must never look like a power cycle
      next_low_cnt = '0;
    end else if (link.alert_low) begin
      if (low_cnt != CW'(MIN_CYC)) begin
        next_low_cnt = low_cnt + CW'(1);
      end
    end else begin
      next_pcd     = (low_cnt == CW'(MIN_CYC));
      next_low_cnt = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      low_cnt <= '0;
      pcd     <= 1'b0;
    end else begin
      low_cnt <= next_low_cnt;
      pcd     <= next_pcd;
    end
  end

  assign link.pcd = pcd;

endmodule

// ### rtl/dw_wake_gen.sv
// Purpose: Wake pulse oscillator, short pulses at a fixed repeat period
// Assumes: wake_req is a level held by the top while wake is wanted
// Notes:   Dropping wake_req ends a pulse at once
`timescale 1ns/10ps

module dw_wake_gen #(
  parameter int PULSE_CYC = dw_pkg::WAKE_PULSE_CYC,
  parameter int REP_CYC   = dw_pkg::WAKE_REP_CYC
) (
  input  wire logic clk_sys,
  input  wire logic nrst,
  dw_link_if.gen    link
);

  localparam int CW = $clog2(REP_CYC + 1);

  dw_pkg::dw_wake_state_type state;
  dw_pkg::dw_wake_state_type next_state;
  logic [CW-1:0]             cnt;
  logic [CW-1:0]             next_cnt;

  if (PULSE_CYC < 1 || REP_CYC <= PULSE_CYC) begin : g_chk
    $error("dw_wake_gen: need 1 <= PULSE_CYC < REP_CYC");
  end

  // ----------------------------------------
  // Pulse sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_cnt   = cnt + CW'(1);
    if (!link.run || !link.wake_req) begin
      next_state = dw_pkg::ws_idle;
      next_cnt   = '0;
    end else begin
      unique case (state)
        dw_pkg::ws_idle: begin
          next_state = dw_pkg::ws_pulse;
          next_cnt   = '0;
        end
        dw_pkg::ws_pulse: begin
          if (cnt == CW'(PULSE_CYC - 1)) begin
            next_state = dw_pkg::ws_gap;
          end
        end
        dw_pkg::ws_gap: begin
          if (cnt == CW'(REP_CYC - 1)) begin
            next_state = dw_pkg::ws_pulse;
            next_cnt   = '0;
          end
        end
        default: begin
          next_state = dw_pkg::ws_idle;
          next_cnt   = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= dw_pkg::ws_idle;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  assign link.pulse = (state == dw_pkg::ws_pulse) && link.wake_req;

endmodule

// ### tb/dw_droop_wake_props.sv
// Purpose: Port-level assertions for the droop wake and enable-switch block
// Assumes: One clock domain, nrst asynchronous and active low
// Notes:   Pulse figures follow the parameters of the bound instance
`timescale 1ns/10ps

module dw_droop_wake_props #(
  parameter int PLS = 5,
  parameter int REP = 60
) (
  input wire logic                     clk_sys,
  input wire logic                     nrst,
  input wire logic                     uvlo_ok,
  input wire logic [dw_pkg::VDD_W-1:0] vdd_level,
  input wire logic                     alert_in,
  input wire logic                     alert_out,
  input wire logic                     alert_oe,
  input wire logic                     ens_out,
  input wire logic                     ens_oe,
  input wire logic                     wake_active,
  input wire logic                     ref_valid,
  input wire logic [dw_pkg::VDD_W-1:0] droop_ref
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  logic droop_seen;
  int   hi_cnt;
  int   wk_run;

  assign droop_seen = ref_valid && (vdd_level < droop_ref);

  // Saturating, so a long unanswered wake cannot wrap the run length
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hi_cnt <= 0;
      wk_run <= 0;
    end else begin
      hi_cnt <= alert_oe ? hi_cnt + 1 : 0;
      wk_run <= wake_active ? ((wk_run < 1000) ? wk_run + 1 : wk_run) : 0;
    end
  end

  sequence wake_held;
    $rose(wake_active) ##1 wake_active;
  endsequence

  sequence pulse_done;
    $fell(alert_oe) ##0 (wake_active && $past(wake_active));
  endsequence

  a_ref_scale: assert property (ref_valid && $changed(droop_ref) |->
    droop_ref == 10'(($past(vdd_level) * dw_pkg::REF_NUM) / dw_pkg::REF_DEN))
    else $error("reference is not the scaled supply");
  a_wake_cause: assert property ($rose(wake_active) |-> $past(droop_seen))
    else $error("wake raised without a droop");
  a_pulse_start: assert property (wake_held |-> ##1 alert_oe)
    else $error("no wake pulse after the wake condition");
  a_pulse_width: assert property (pulse_done |-> hi_cnt == PLS)
    else $error("wake pulse width wrong");
  a_pulse_repeat: assert property ($rose(alert_oe) |-> ##[REP:REP] (alert_oe || wk_run < REP))
    else $error("wake pulse did not repeat on time");
  a_oe_gated: assert property (alert_oe |-> wake_active || $past(wake_active) || $past(wake_active, 2))
    else $error("alert pulled low outside wake");
  a_pins_low: assert property (alert_out == 1'b0 && ens_out == 1'b0)
    else $error("open-drain data not low");
  a_wake_ref: assert property (wake_active |-> ref_valid)
    else $error("wake before any reference");
  a_ref_hold: assert property (wake_active && $past(wake_active) |-> $stable(droop_ref))
    else $error("reference moved during wake");
  a_ens_quiet: assert property ($changed(ens_oe) |-> !wake_active)
    else $error("enable switch moved during wake");
  a_lockout: assert property (!uvlo_ok |=> !ref_valid && !wake_active && !ens_oe)
    else $error("state kept under lockout");
endmodule

bind dw_droop_wake dw_droop_wake_props #(
  .PLS (WAKE_PLS_CYC),
  .REP (WAKE_REP_CYC)
) chk (
  .clk_sys, .nrst, .uvlo_ok, .vdd_level, .alert_in, .alert_out,
  .alert_oe, .ens_out, .ens_oe, .wake_active, .ref_valid, .droop_ref
);

// ### tb/dw_psr_model.sv
// Purpose: Far-side controller stand-in making power cycles on the alert pin
// Assumes: alert_in is high while the pin sits below the detect level
// Notes:   Answers a wake pulse only while answer is high, else stays silent
`timescale 1ns/10ps

module dw_psr_model (
  input  wire logic       clk_sys,
  input  wire logic       alert_oe,
  input  wire logic       fire,
  input  wire logic       answer,
  input  wire logic [3:0] low_len,
  output logic            alert_in
);
  logic [3:0] cnt  = 4'h0;
  logic [1:0] oe_d = 2'h0;

  // Cycles start on fire, or after a wake pulse ends while answer is high; fire sets every other period, short or long
  always_ff @(posedge clk_sys) begin
    oe_d <= {oe_d[0], alert_oe};
    if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (fire || (answer && oe_d == 2'h2)) begin
      cnt <= low_len;
    end
  end

  // Both pull-downs share the pin
  assign alert_in = alert_oe || (cnt != 4'h0);
endmodule

// ### tb/test_droop_wake_and_sr_enable_logic.sv
// Purpose: Self-checking bench for the droop wake and enable-switch block
// Assumes: Short timing parameters, switch counts kept at their real values
// Notes:   Outputs are read just after an edge, before its updates land
`timescale 1ns/10ps

module test_droop_wake_and_sr_enable_logic;
  localparam int PLS  = 5;
  localparam int REP  = 60;
  localparam int ECNT = 32;

  typedef struct {
    logic [9:0] vdd;
    logic [9:0] ref_exp;
  } dw_row_type;

  // Ascending supply, so no row drops under the reference before it
  dw_row_type rows [5] = '{'{10'h021, 10'h020}, '{10'h064, 10'h061},
    '{10'h1f4, 10'h1e5}, '{10'h3e8, 10'h3ca}, '{10'h3ff, 10'h3e0}};

  logic                     clk_sys   = 1'b0;
  logic                     nrst      = 1'b0;
  logic                     uvlo_ok   = 1'b0;
  logic                     fire      = 1'b0;
  logic                     answer    = 1'b0;
  logic [3:0]               low_len   = 4'h5;
  logic [dw_pkg::VDD_W-1:0] vdd_level = 10'h000;
  logic                     alert_in, alert_out, alert_oe, ens_out, ens_oe, wake_active, ref_valid;
  logic [dw_pkg::VDD_W-1:0] droop_ref;
  int                       errors      = 0;
  int                       check_count = 0;
  int                       n;

  dw_droop_wake #(
    .PCD_MIN_CYC  (4),
    .WAKE_PLS_CYC (PLS),
    .WAKE_REP_CYC (REP),
    .ENS_CYC      (20),
    .DISS_CYC     (60)
  ) uut (.clk_sys, .nrst, .uvlo_ok, .vdd_level, .alert_in, .alert_out, .alert_oe,
         .ens_out, .ens_oe, .wake_active, .ref_valid, .droop_ref);

  dw_psr_model psr (.clk_sys, .alert_oe, .fire, .answer, .low_len, .alert_in);

  always #2.5 clk_sys = ~clk_sys;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  // One power cycle now; the next may start p edges later
  task automatic pcycle(input int p);
    @(posedge clk_sys);
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
    tick(p - 2);
  endtask

  task automatic wait_oe(input logic lvl);
    n = 0;
    while (alert_oe !== lvl && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 100) begin
      errors++;
      $display("[FAIL] %0t wake pin wait ran out", $time);
      final_report();
    end
  endtask

  initial begin
    tick(2);
    nrst <= 1'b1;
    tick(1);
    check({ens_oe, alert_oe, wake_active, ref_valid}, 16'h0000);
    uvlo_ok <= 1'b1;
    foreach (rows[i]) begin
      vdd_level <= rows[i].vdd;
      pcycle(12);
      check(droop_ref, rows[i].ref_exp);
      check(ref_valid, 1'b1);
    end
    $display("reference rows done");
    // A low phase one cycle short is noise; a full one reloads at the present level
    vdd_level <= 10'h3e8;
    low_len <= 4'h3;
    pcycle(12);
    check(droop_ref, 10'h3e0);
    low_len <= 4'h5;
    pcycle(12);
    check(droop_ref, 10'h3ca);
    vdd_level <= 10'h3d4;
    tick(4);
    check(wake_active, 1'b0);
    $display("detection filter done");
    vdd_level <= 10'h3c0;
    tick(3);
    check(wake_active, 1'b1);
    wait_oe(1'b1);
    wait_oe(1'b0);
    check(16'(n), 16'(PLS));
    wait_oe(1'b1);
    check(16'(n), 16'(REP - PLS));
    check(droop_ref, 10'h3ca);
    answer <= 1'b1;
    tick(20);
    check({wake_active, droop_ref}, {1'b0, 10'h3a3});
    tick(REP);
    check({alert_oe, ens_oe}, 2'h0);
    answer <= 1'b0;
    $display("wake signalling done");
    uvlo_ok <= 1'b0;
    tick(1);
    uvlo_ok <= 1'b1;
    tick(2);
    check({ref_valid, wake_active, ens_oe}, 3'h0);
    vdd_level <= 10'h3e8;
    repeat (62) pcycle(80);
    pcycle(12);
    check(ens_oe, 1'b0);
    for (int i = 0; i < 64; i++) begin
      pcycle(80);
      if (i == 62) check(ens_oe, 1'b0);
    end
    check(ens_oe, 1'b1);
    for (int j = 1; j < ECNT; j++) begin
      pcycle(12);
      pcycle(80);
      if (j == ECNT - 2) check(ens_oe, 1'b1);
    end
    check(ens_oe, 1'b0);
    $display("enable switch done");
    final_report();
  end
endmodule
